// ==== hw/fbm_pkg.sv ====
// constants and types shared by the fieldbus slave I/O map
package fbm_pkg;
    localparam int BIT_WORDS = 6;
    localparam int IMG_BITS = 96;
    localparam int REG_WORDS = 10;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 9;
    localparam int SPACE_POS = 8;
    localparam int BIT_STEP = 2;
    localparam int REG_STEP = 4;
    localparam int REG_SPAN = 12;
    localparam int STATION_W = 6;
    localparam int SIZE_W = 6;
    localparam int CTL_BIT_BASE = 512;
    localparam int CTL_WORD_BASE = 38;
    localparam int READY_CTL_BIT = 603;
    localparam int READY_POS = READY_CTL_BIT - CTL_BIT_BASE;
    localparam int FAULT_W = 14;
    localparam int CMD_W = 12;
    localparam int STATION_BYTES = 12;
    localparam int BIT_BYTES_PER_STATION = 4;
    localparam int MAX_STATIONS = 4;
    localparam logic [STATION_W-1:0] STATION_RST = 6'h01;
    localparam logic [SIZE_W-1:0] SIZE_RST = 6'h00;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    typedef enum logic [0:0] {
        FBM_WAIT_INIT = 1'b0,
        FBM_ONLINE = 1'b1
    } fbm_state_t;
endpackage

// ==== hw/fbm_sync.sv ====
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module fbm_sync
    import fbm_pkg::*;
(
    input wire logic clock, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic async_in, // level from outside
    output logic sync_out // synchronised level
);
    logic stage1;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ==== hw/fbm_occupancy.sv ====
// occupied stations and image sizes from the configured I/O byte size
`timescale 1ns/10ps
module fbm_occupancy
    import fbm_pkg::*;
(
    input wire logic [SIZE_W-1:0] io_size, // configured I/O bytes
    output logic [2:0] stations, // occupied stations 1..4
    output logic [3:0] bit_words, // bit image words claimed, two per station
    output logic [3:0] reg_words // usable register words
);
    logic [SIZE_W-1:0] bit_bytes;
    logic [SIZE_W-1:0] reg_bytes;
    logic [SIZE_W-1:0] reg_half;
    // sizes above the documented maximum fall into four stations
    assign stations = (io_size <= SIZE_W'(STATION_BYTES)) ? 3'h1 :   // [R10]
                      (io_size <= SIZE_W'(2*STATION_BYTES)) ? 3'h2 :
                      (io_size <= SIZE_W'(3*STATION_BYTES)) ? 3'h3 : 3'h4;
    assign bit_bytes = SIZE_W'(BIT_BYTES_PER_STATION) * SIZE_W'(stations); // [R10]
    assign reg_bytes = (io_size > bit_bytes) ? io_size - bit_bytes : SIZE_W'(0);
    // an odd register byte still claims a whole word
    assign reg_half = SIZE_W'((reg_bytes + SIZE_W'(1)) >> 1);
    assign bit_words = 4'(SIZE_W'(stations) * SIZE_W'(BIT_STEP));
    assign reg_words = (reg_half > SIZE_W'(REG_WORDS)) ? 4'(REG_WORDS) : reg_half[3:0];
endmodule

// ==== hw/fbm_io_map.sv ====
// fieldbus slave station I/O map between network image and controller I/O
//
// Function
// [R1] with remote allocation, status bits drive master-bound bits n..n+1 from bit 512.
// [R2] fault number appears as fourteen binary weights on bits 527 to 540.
// [R3] remote ready at n+5 bit B after init; fixed, never relocated or disabled.
// [R4] status and command functions are plain user bits until allocation is enabled.
// [R5] master bits n.0 to n.B drive the twelve commands, bits 512 to 523.
// [R6] unassigned bits pass through unchanged up to controller bit 607.
// [R7] register word offset m equals four times station minus one.
// [R8] master-bound register words m..m+9 come from words 38..47; A,B reserved.
// [R9] master-driven register words m..m+9 land in words 38..47; A,B reserved.
// [R10] occupied stations follow I/O size in steps of twelve bytes.
// [R11] bit and register data move in whole 16-bit words.
// [R12] the master must be set to the same occupied station count.
// [R13] station 1 uses bit words 0..5; station 4 starts at word 6.
// [R14] bit word offset n equals twice station minus one.
// [R15] remote ready stays low and master writes are dropped until init completes.
`timescale 1ns/10ps
module fbm_io_map
    import fbm_pkg::*;
(
    input wire logic clock, // 50 MHz system clock
    input wire logic nrst, // async reset, active low
    input wire logic board_init_done, // board init finished, from pin
    input wire logic [STATION_W-1:0] station_number, // configured station, 1..63
    input wire logic [SIZE_W-1:0] io_size, // configured I/O bytes
    input wire logic remote_alloc_enable, // route remote control bits
    input wire logic [ADDR_W-1:0] address, // network word address, bit 8 selects words
    input wire logic [WORD_W-1:0] write_data, // master-driven word
    input wire logic write_strobe, // master write, one cycle
    input wire logic read_strobe, // master read, one cycle
    output logic [WORD_W-1:0] read_data, // master-bound word, cycle after read
    input wire logic status_ready, // controller ready
    input wire logic status_start, // program running
    input wire logic status_paused, // program paused
    input wire logic status_error, // error present
    input wire logic emergency_stop_active, // emergency stop engaged
    input wire logic guard_open_active, // safeguard open
    input wire logic critical_fault, // critical error
    input wire logic status_warning, // warning present
    input wire logic drives_energized, // motors on
    input wire logic at_park_position, // at home
    input wire logic [2:0] running_program_weight, // current program number
    input wire logic automatic_operation, // auto mode
    input wire logic manual_teach_operation, // teach mode
    input wire logic [FAULT_W-1:0] fault_number_bit, // current error number
    input wire logic remote_command_active, // command running
    input wire logic remote_command_fault, // command failed
    input wire logic [IMG_BITS-1:0] user_bits_in, // program bits 512..607 to master
    input wire logic [REG_WORDS*WORD_W-1:0] user_words_in, // words 38..47 to master
    output logic [IMG_BITS-1:0] user_bits_out, // master bits to 512..607
    output logic [REG_WORDS*WORD_W-1:0] user_words_out, // master words to 38..47
    output logic start_request, // start command
    output logic [2:0] program_select_weight, // program select
    output logic stop_request, // stop command
    output logic pause_request, // pause command
    output logic continue_request, // continue command
    output logic reset_request, // reset command
    output logic energize_drives_request, // motors on command
    output logic deenergize_drives_request, // motors off command
    output logic home_request, // home command
    output logic shutdown_request, // shutdown command
    output logic remote_ready, // remote ready flag
    output logic [2:0] occupied_stations // stations to set in the master
);
    fbm_state_t state;
    fbm_state_t next_state;
    logic init_seen;
    logic [STATION_W-1:0] station_q;
    logic [SIZE_W-1:0] size_q;
    logic [IMG_BITS-1:0] ry_image;
    logic [WORD_W-1:0] rw_image [REG_WORDS];
    logic [CMD_W-1:0] cmd_q;
    logic [2:0] stations_w;
    logic [3:0] bit_words_w;
    logic [3:0] reg_words_w;

    fbm_sync u_init_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in(board_init_done),
        .sync_out(init_seen)
    );

    fbm_occupancy u_occupancy (
        .io_size(size_q),
        .stations(stations_w),
        .bit_words(bit_words_w),
        .reg_words(reg_words_w)
    );

    // ready is sticky: once init is seen only reset clears it
    assign next_state = (state == FBM_ONLINE || init_seen) ? FBM_ONLINE : FBM_WAIT_INIT;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= FBM_WAIT_INIT;
        end else begin
            state <= next_state;
        end
    end

    // configuration is caught as the board comes online so offsets never move mid-run
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            station_q <= STATION_RST;
            size_q <= SIZE_RST;
        end else if (state == FBM_WAIT_INIT) begin
            station_q <= station_number;
            size_q <= io_size;
        end
    end

    // offsets; station 0 is treated as station 1
    logic [STATION_W-1:0] st_minus1;
    logic [7:0] base_n;
    logic [7:0] base_m;
    assign st_minus1 = (station_q == '0) ? '0 : station_q - STATION_W'(1);
    assign base_n = 8'(st_minus1) * 8'(BIT_STEP); // [R14] [R13]
    assign base_m = 8'(st_minus1) * 8'(REG_STEP); // [R7]

    // address decode
    logic is_reg_space;
    logic [7:0] word_idx;
    logic [7:0] bit_rel;
    logic [7:0] reg_rel;
    logic bit_hit;
    logic reg_hit;
    logic [7:0] bit_span;
    assign is_reg_space = address[SPACE_POS];
    assign word_idx = address[7:0];
    assign bit_rel = word_idx - base_n;
    assign reg_rel = word_idx - base_m;
    // four stations claim eight bit words, but only six are backed by controller bits
    assign bit_span = (bit_words_w > 4'(BIT_WORDS)) ? 8'(BIT_WORDS) : 8'(bit_words_w);
    assign bit_hit = !is_reg_space && word_idx >= base_n && bit_rel < bit_span; // [R13] [R6]
    // words m+A and m+B fall outside reg_words and so read zero and drop writes
    assign reg_hit = is_reg_space && word_idx >= base_m && reg_rel < 8'(reg_words_w); // [R8] [R9]

    // master-bound bit image
    logic [WORD_W-1:0] status_lo;
    logic [WORD_W-1:0] status_hi;
    logic [2*WORD_W-1:0] low_words;
    logic [IMG_BITS-1:0] rx_image;
    assign status_lo = {fault_number_bit[0], manual_teach_operation, automatic_operation, // [R2]
                        running_program_weight, at_park_position, drives_energized, // [R1]
                        status_warning, critical_fault, guard_open_active,
                        emergency_stop_active, status_error, status_paused,
                        status_start, status_ready};
    assign status_hi = {user_bits_in[31], remote_command_fault, remote_command_active, // [R1]
                        fault_number_bit[FAULT_W-1:1]}; // [R2]
    assign low_words = remote_alloc_enable ? {status_hi, status_lo} : user_bits_in[31:0]; // [R4]
    assign rx_image = {user_bits_in[IMG_BITS-1:READY_POS+1], remote_ready, // [R3]
                       user_bits_in[READY_POS-1:2*WORD_W], low_words}; // [R6]

    logic [WORD_W-1:0] rx_word;
    logic [WORD_W-1:0] rw_in_word;
    logic [WORD_W-1:0] next_read_data;
    assign rx_word = rx_image[bit_rel[2:0]*WORD_W +: WORD_W]; // [R11]
    assign rw_in_word = user_words_in[reg_rel[3:0]*WORD_W +: WORD_W]; // [R8]
    assign next_read_data = !read_strobe ? WORD_RST :
                            bit_hit ? rx_word :
                            reg_hit ? rw_in_word : WORD_RST;

    // read data stands for exactly one cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            read_data <= WORD_RST;
        end else begin
            read_data <= next_read_data;
        end
    end

    logic write_ok;
    assign write_ok = write_strobe && state == FBM_ONLINE; // [R15]

    // master-driven bit image, written a whole word at a time
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ry_image <= '0;
        end else if (write_ok && bit_hit) begin
            ry_image[bit_rel[2:0]*WORD_W +: WORD_W] <= write_data; // [R11] [R6]
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < REG_WORDS; gi++) begin : g_rw
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    rw_image[gi] <= WORD_RST;
                end else if (write_ok && reg_hit && reg_rel[3:0] == 4'(gi)) begin
                    rw_image[gi] <= write_data; // [R9]
                end
            end
            assign user_words_out[gi*WORD_W +: WORD_W] = rw_image[gi]; // [R9]
        end
    endgenerate

    assign user_bits_out = ry_image; // [R6]

    // commands reach the controller only with allocation on
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cmd_q <= '0;
        end else begin
            cmd_q <= remote_alloc_enable ? ry_image[CMD_W-1:0] : '0; // [R5] [R4]
        end
    end

    assign start_request = cmd_q[0]; // [R5]
    assign program_select_weight = cmd_q[3:1];
    assign stop_request = cmd_q[4];
    assign pause_request = cmd_q[5];
    assign continue_request = cmd_q[6];
    assign reset_request = cmd_q[7];
    assign energize_drives_request = cmd_q[8];
    assign deenergize_drives_request = cmd_q[9];
    assign home_request = cmd_q[10];
    assign shutdown_request = cmd_q[11];

    // ready and station count registered so outputs come straight from flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            remote_ready <= 1'b0;
            occupied_stations <= 3'h1;
        end else begin
            remote_ready <= (state == FBM_ONLINE); // [R3] [R15]
            occupied_stations <= stations_w; // [R10] [R12]
        end
    end
endmodule

// ==== verification/fbm_io_map_asserts.sv ====
// port assertions for the fieldbus slave I/O map
`timescale 1ns/10ps
module fbm_io_map_asserts
    import fbm_pkg::*;
(
    input wire logic clock, // clock
    input wire logic nrst, // reset
    input wire logic board_init_done, // init level
    input wire logic [STATION_W-1:0] station_number, // station
    input wire logic [SIZE_W-1:0] io_size, // bytes
    input wire logic remote_alloc_enable, // allocation
    input wire logic [ADDR_W-1:0] address, // address
    input wire logic write_strobe, // write
    input wire logic read_strobe, // read
    input wire logic [WORD_W-1:0] read_data, // read word
    input wire logic [IMG_BITS-1:0] user_bits_in, // to master
    input wire logic [IMG_BITS-1:0] user_bits_out, // from master
    input wire logic start_request, // command
    input wire logic [2:0] program_select_weight, // command
    input wire logic shutdown_request, // command
    input wire logic remote_ready, // ready
    input wire logic [2:0] occupied_stations // stations
);
    wire logic [ADDR_W-1:0] bit_n = ADDR_W'((station_number - 6'h01) * 2);
    wire logic [4:0] cmd_img = {user_bits_out[11], user_bits_out[3:0]};
    wire logic [4:0] cmd_out = {shutdown_request, program_select_weight, start_request};
    wire logic [WORD_W-1:0] word2 = user_bits_in[47:32];
    wire logic [2:0] exp_st = (io_size <= 6'h0c) ? 3'h1 : (io_size <= 6'h18) ? 3'h2 :
        (io_size <= 6'h24) ? 3'h3 : 3'h4;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    a_ready_after_init: assert property ($rose(remote_ready) |->
        $past(board_init_done, 2) && $past(board_init_done, 3)) else $error("ready too early");
    a_ready_in_time: assert property (board_init_done [*8] |-> remote_ready)
        else $error("ready missing");
    a_ready_holds: assert property (remote_ready |=> remote_ready)
        else $error("ready dropped");
    a_ready_bit_read: assert property (read_strobe && address == bit_n + 9'h005 &&
        remote_ready && occupied_stations > 3'h2 |=> read_data[11]) else $error("ready bit low");
    a_user_word_pass: assert property (read_strobe && address == bit_n + 9'h002 &&
        occupied_stations > 3'h1 |=> read_data == $past(word2)) else $error("user word wrong");
    a_cmd_mapped: assert property ($past(remote_alloc_enable) |-> cmd_out == $past(cmd_img))
        else $error("command not from image");
    a_cmd_plain: assert property (!$past(remote_alloc_enable) |-> cmd_out == 5'h00)
        else $error("command while unallocated");
    a_early_write: assert property (write_strobe && !remote_ready ##1 !remote_ready [*2]
        |-> user_bits_out == $past(user_bits_out, 2)) else $error("write taken before ready");
    a_occupied: assert property (remote_ready |-> occupied_stations == exp_st)
        else $error("station count wrong");
    a_read_idle: assert property (!$past(read_strobe) |-> read_data == 16'h0000)
        else $error("read data outside its cycle");
endmodule
bind fbm_io_map fbm_io_map_asserts u_chk (
    .clock(clock), .nrst(nrst), .board_init_done(board_init_done),
    .station_number(station_number), .io_size(io_size),
    .remote_alloc_enable(remote_alloc_enable), .address(address),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .user_bits_in(user_bits_in), .user_bits_out(user_bits_out),
    .start_request(start_request), .program_select_weight(program_select_weight),
    .shutdown_request(shutdown_request), .remote_ready(remote_ready),
    .occupied_stations(occupied_stations)
);

// ==== verification/fbm_plc_model.sv ====
// behavioural master station driving the slave's word access port
`timescale 1ns/10ps
module fbm_plc_model
    import fbm_pkg::*;
(
    input wire logic clock, // system clock
    input wire logic [WORD_W-1:0] read_data, // word from slave
    input wire logic [2:0] occupied_stations, // slave station count
    output logic [ADDR_W-1:0] address, // word address
    output logic [WORD_W-1:0] write_data, // word to slave
    output logic write_strobe, // one cycle write
    output logic read_strobe // one cycle read
);
    logic [2:0] plc_stations = 3'h1;
    logic slow = 1'b0;
    initial begin
        address = 9'h000;
        write_data = 16'h0000;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
    end
    // master span follows the slave's count
    always @(posedge clock) plc_stations <= occupied_stations;
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        repeat (slow ? 3 : 1) @(posedge clock);
        write_strobe <= 1'b1;
        address <= a;
        write_data <= d;
        @(posedge clock);
        write_strobe <= 1'b0;
        // released data must not look valid
        write_data <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
        repeat (slow ? 3 : 1) @(posedge clock);
        read_strobe <= 1'b1;
        address <= a;
        @(posedge clock);
        read_strobe <= 1'b0;
        @(negedge clock);
        d = read_data;
    endtask
endmodule

// ==== verification/fbm_io_map_tb.sv ====
// self-checking bench for the fieldbus slave I/O map
`timescale 1ns/10ps
module fbm_io_map_tb;
    import fbm_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic board_init_done = 1'b0;
    logic [STATION_W-1:0] station_number = 6'h01;
    logic [SIZE_W-1:0] io_size = 6'h24;
    logic remote_alloc_enable = 1'b1;
    logic [30:0] stat = 31'h3b3c_a6e1;
    logic [IMG_BITS-1:0] ubi = 96'h0123_4567_89ab_cdef_fedc_ba98;
    logic [REG_WORDS*WORD_W-1:0] uwi;
    logic [SIZE_W-1:0] sz_tab [8] = '{6'h01, 6'h0c, 6'h0d, 6'h18, 6'h19, 6'h24, 6'h25, 6'h30};
    wire logic [ADDR_W-1:0] address;
    wire logic [WORD_W-1:0] write_data, read_data;
    wire logic write_strobe, read_strobe, remote_ready;
    wire logic [IMG_BITS-1:0] ubo;
    wire logic [REG_WORDS*WORD_W-1:0] uwo;
    wire logic [11:0] cmd;
    wire logic [2:0] occupied_stations;
    int fails = 0;
    int compares = 0;
    always #10 clock = ~clock;
    fbm_plc_model plc (.clock(clock), .read_data(read_data),
        .occupied_stations(occupied_stations), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe));
    fbm_io_map dut (.clock(clock), .nrst(nrst), .board_init_done(board_init_done),
        .station_number(station_number), .io_size(io_size),
        .remote_alloc_enable(remote_alloc_enable), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .status_ready(stat[0]), .status_start(stat[1]), .status_paused(stat[2]),
        .status_error(stat[3]), .emergency_stop_active(stat[4]), .guard_open_active(stat[5]),
        .critical_fault(stat[6]), .status_warning(stat[7]), .drives_energized(stat[8]),
        .at_park_position(stat[9]), .running_program_weight(stat[12:10]),
        .automatic_operation(stat[13]), .manual_teach_operation(stat[14]),
        .fault_number_bit(stat[28:15]), .remote_command_active(stat[29]),
        .remote_command_fault(stat[30]), .user_bits_in(ubi), .user_words_in(uwi),
        .user_bits_out(ubo), .user_words_out(uwo), .start_request(cmd[0]),
        .program_select_weight(cmd[3:1]), .stop_request(cmd[4]), .pause_request(cmd[5]),
        .continue_request(cmd[6]), .reset_request(cmd[7]), .energize_drives_request(cmd[8]),
        .deenergize_drives_request(cmd[9]), .home_request(cmd[10]),
        .shutdown_request(cmd[11]), .remote_ready(remote_ready),
        .occupied_stations(occupied_stations));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        logic [15:0] d;
        plc.rd(a, d);
        chk("read word", exp, d);
    endtask
    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        end_sim;
    end
    initial begin
        for (int k = 0; k < REG_WORDS; k++) uwi[k*16+:16] = 16'h7000 + 16'(k);
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        // size latches only while waiting for init
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            io_size <= sz_tab[i];
            repeat (3) @(negedge clock);
            chk("stations", 16'(i / 2 + 1), 16'(occupied_stations));
        end
        @(posedge clock);
        io_size <= 6'h24;
        plc.wr(9'h000, 16'hffff);
        rchk(9'h005, 16'h0123);
        @(posedge clock);
        board_init_done <= 1'b1;
        for (int i = 0; i < 20 && remote_ready !== 1'b1; i++) @(posedge clock);
        chk("ready", 16'h0001, 16'(remote_ready));
        chk("early image", 16'h0000, ubo[15:0]);
        chk("master stations", 16'h0003, 16'(plc.plc_stations));
        rchk(9'h005, 16'h0923);
        rchk(9'h000, stat[15:0]);
        rchk(9'h001, {ubi[31], stat[30:16]});
        rchk(9'h002, ubi[47:32]);
        rchk(9'h006, 16'h0000);
        rchk(9'h100, 16'h7000);
        rchk(9'h109, 16'h7009);
        rchk(9'h10a, 16'h0000);
        plc.wr(9'h000, 16'hfa5c);
        @(negedge clock);
        chk("image word", 16'hfa5c, ubo[15:0]);
        @(negedge clock);
        chk("commands", 16'h0a5c, 16'(cmd));
        plc.wr(9'h005, 16'h8421);
        plc.wr(9'h006, 16'h1111);
        plc.wr(9'h109, 16'hbeef);
        plc.wr(9'h10b, 16'h2222);
        @(negedge clock);
        chk("image top", 16'h8421, ubo[95:80]);
        chk("image low", 16'hfa5c, ubo[15:0]);
        chk("reg word", 16'hbeef, uwo[159:144]);
        chk("reg low", 16'h0000, uwo[15:0]);
        plc.slow = 1'b1;
        @(posedge clock);
        remote_alloc_enable <= 1'b0;
        rchk(9'h000, ubi[15:0]);
        rchk(9'h001, ubi[31:16]);
        chk("commands off", 16'h0000, 16'(cmd));
        plc.slow = 1'b0;
        @(posedge clock);
        nrst <= 1'b0;
        station_number <= 6'h04;
        io_size <= 6'h30;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        repeat (10) @(negedge clock);
        chk("stations", 16'h0004, 16'(occupied_stations));
        chk("master stations", 16'h0004, 16'(plc.plc_stations));
        rchk(9'h006, ubi[15:0]);
        rchk(9'h009, ubi[63:48]);
        rchk(9'h00a, ubi[79:64]);
        rchk(9'h00b, 16'h0923);
        rchk(9'h00c, 16'h0000);
        rchk(9'h005, 16'h0000);
        rchk(9'h10c, 16'h7000);
        rchk(9'h10f, 16'h7003);
        rchk(9'h115, 16'h7009);
        rchk(9'h116, 16'h0000);
        plc.wr(9'h006, 16'h0c03);
        @(negedge clock);
        chk("station image", 16'h0c03, ubo[15:0]);
        end_sim;
    end
endmodule
